// >>> design/jdr_top.sv
// Operation
// [RULE1] ID register: version, device, maker, one
// [RULE2] User code: firmware byte, slave address, zeros
// [RULE3] User code loads at capture, shifts out
// [RULE4] Load-address selects 8-bit address register
// [RULE5] Read selects 8-bit read data register
// [RULE6] Write selects 8-bit write data register
// [RULE7] Reboot instruction resets and restarts boot
// [RULE8] Save instruction triggers fault log copy
// [RULE9] Sample or extest selects 198-bit chain
// [RULE10] One cell per pin, two per address
// [RULE11] Reserved cells carry zeros
// [RULE12] Sample captures outputs without disturbing operation
// [RULE13] Extest drives pins from cells, captures inputs
// [RULE14] Output cells sit at 148 to 156
// [RULE15] Input cells sit at 183 to 190
// [RULE16] Address cells a,b: 00 Z, 01 low, 10 high
// [RULE17] Five-bit IR; usercode, load-address, read opcodes
// [RULE18] Write, reboot, save opcodes; bypass all ones
// [RULE19] IDCODE, sample, extest opcodes; IDCODE on reset
// [RULE20] Host loads address before read or write
`timescale 1ns/1ps
`include "jdr_consts.svh"

module jdr_top
	import jdr_pkg::*;
#(
	parameter logic [3:0] ID_VERSION = 4'h1, // Arbitrary identity value.
	parameter logic [15:0] ID_DEVICE = 16'h00A5, // Arbitrary identity value.
	parameter logic [10:0] ID_MAKER = 11'h05A // Arbitrary identity value.
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	input wire jdr_pin_out_t func_out,
	output jdr_pin_out_t pin_out,
	input wire jdr_pin_in_t pin_in,
	output jdr_mem_req_t mem_req,
	input wire logic [7:0] mem_rdata,
	output logic reboot_pulse,
	output logic save_pulse,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	logic [2:0] tck_sync;
	logic [1:0] tms_sync;
	logic [1:0] tdi_sync;
	jdr_pin_in_t pin_meta;
	jdr_pin_in_t pin_sync;
	logic tck_rise;
	logic tck_fall;
	jdr_tap_t tap;
	jdr_tap_t next_tap;
	logic [`JDR_IR_LEN-1:0] ir_shift;
	logic [`JDR_IR_LEN-1:0] instr;
	logic [`JDR_BSR_LEN-1:0] dr_shift;
	logic [`JDR_BSR_LEN-1:0] next_dr_shift;
	logic [`JDR_BSR_LEN-1:0] bsr_hold;
	logic [`JDR_BSR_LEN-1:0] bsr_capture;
	logic [7:0] mem_addr;
	logic [7:0] mem_wdata;
	logic [31:0] cfg;
	logic [31:0] id_code;
	logic [31:0] user_code;
	logic extest_on;

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------

	// Length of the data register selected by an instruction.
	function automatic logic [7:0] dr_len(input logic [`JDR_IR_LEN-1:0] op);
		logic [7:0] len;
		len = 8'h01;
		if (op == `JDR_OP_IDCODE || op == `JDR_OP_USERCODE) begin
			len = 8'(`JDR_ID_LEN);
		end else if (op == `JDR_OP_SAMPLE || op == `JDR_OP_EXTEST) begin
			len = 8'(`JDR_BSR_LEN); // see [RULE9]
		end else if (op == `JDR_OP_LOAD_ADDR || op == `JDR_OP_READ || op == `JDR_OP_WRITE) begin
			len = 8'(`JDR_MEM_LEN); // see [RULE4] see [RULE5] see [RULE6]
		end
		return len;
	endfunction : dr_len

	// True when a boundary instruction is selected.
	function automatic logic is_bsr(input logic [`JDR_IR_LEN-1:0] op);
		return (op == `JDR_OP_SAMPLE) || (op == `JDR_OP_EXTEST);
	endfunction : is_bsr

	// ------------------------------------------------------------------------
	// Synchronisers and TCK edge detection
	// ------------------------------------------------------------------------

	// Two flip-flops on every pin before any logic reads it.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tck_sync <= 3'h0;
			tms_sync <= 2'h3;
			tdi_sync <= 2'h3;
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			tck_sync <= {tck_sync[1:0], tck};
			tms_sync <= {tms_sync[0], tms};
			tdi_sync <= {tdi_sync[0], tdi};
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// Edges are found from the second and third stages only.
	assign tck_rise = tck_sync[1] & ~tck_sync[2];
	assign tck_fall = ~tck_sync[1] & tck_sync[2];

	// ------------------------------------------------------------------------
	// TAP controller
	// ------------------------------------------------------------------------

	// Next state from the synchronised TMS.
	always_comb begin
		next_tap = tap;
		case (tap)
			TAP_RESET: next_tap = tms_sync[1] ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: next_tap = tms_sync[1] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: next_tap = tms_sync[1] ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: next_tap = tms_sync[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: next_tap = tms_sync[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: next_tap = tms_sync[1] ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: next_tap = tms_sync[1] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: next_tap = tms_sync[1] ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: next_tap = tms_sync[1] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: next_tap = tms_sync[1] ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: next_tap = tms_sync[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: next_tap = tms_sync[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: next_tap = tms_sync[1] ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: next_tap = tms_sync[1] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: next_tap = tms_sync[1] ? TAP_UPD_IR : TAP_SHIFT_IR;
			default: next_tap = tms_sync[1] ? TAP_SEL_DR : TAP_IDLE;
		endcase
	end

	// State advances on each rising TCK.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tap <= TAP_RESET;
		end else if (tck_rise) begin
			tap <= next_tap;
		end
	end

	// ------------------------------------------------------------------------
	// Instruction register
	// ------------------------------------------------------------------------

	// Shift path: fixed capture value, then shift toward TDO.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ir_shift <= `JDR_IR_CAPTURE;
		end else if (tck_rise && tap == TAP_CAP_IR) begin
			ir_shift <= `JDR_IR_CAPTURE;
		end else if (tck_rise && tap == TAP_SHIFT_IR) begin
			ir_shift <= {tdi_sync[1], ir_shift[`JDR_IR_LEN-1:1]};
		end
	end

	// Current instruction latches on the falling TCK in update-IR.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			instr <= `JDR_OP_IDCODE;
		end else if (tap == TAP_RESET) begin
			instr <= `JDR_OP_IDCODE; // see [RULE19]
		end else if (tck_fall && tap == TAP_UPD_IR) begin
			instr <= ir_shift; // see [RULE17] see [RULE18]
		end
	end

	// One-cycle actions when reboot or save becomes current.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reboot_pulse <= 1'b0;
			save_pulse <= 1'b0;
		end else begin
			reboot_pulse <= tck_fall && tap == TAP_UPD_IR && ir_shift == `JDR_OP_REBOOT; // see [RULE7]
			save_pulse <= tck_fall && tap == TAP_UPD_IR && ir_shift == `JDR_OP_SAVE; // see [RULE8]
		end
	end

	// ------------------------------------------------------------------------
	// Capture values
	// ------------------------------------------------------------------------

	// Identification and user code words.
	assign id_code = {ID_VERSION, ID_DEVICE, ID_MAKER, 1'b1}; // see [RULE1]
	assign user_code = {17'h0_0000, cfg[`JDR_CFG_SLAVE_POS +: 7], cfg[`JDR_CFG_FW_POS +: 8]}; // see [RULE2]

	// Boundary capture: outputs, inputs, and zeros in every other cell.
	always_comb begin
		bsr_capture = '0; // see [RULE11]
		bsr_capture[`JDR_CELL_GPIO1_OUT] = func_out.gpio1; // see [RULE12] see [RULE14]
		bsr_capture[`JDR_CELL_GPIO2_OUT] = func_out.gpio2;
		bsr_capture[`JDR_CELL_SDA_OUT] = func_out.sda;
		bsr_capture[`JDR_CELL_ALERT] = func_out.alert;
		bsr_capture[`JDR_CELL_FAULT_B] = func_out.secondary_fault_b_out;
		bsr_capture[`JDR_CELL_FAULT_A] = func_out.secondary_fault_a_out;
		bsr_capture[`JDR_CELL_OVERTEMP] = func_out.overtemperature_out;
		bsr_capture[`JDR_CELL_RESET] = func_out.reset;
		bsr_capture[`JDR_CELL_OVERCUR] = func_out.overcurrent_out;
		bsr_capture[`JDR_CELL_GPIO2_IN] = pin_sync.gpio2; // see [RULE13] see [RULE15]
		bsr_capture[`JDR_CELL_GPIO1_IN] = pin_sync.gpio1;
		bsr_capture[`JDR_CELL_SDA_IN] = pin_sync.sda;
		bsr_capture[`JDR_CELL_A0B] = pin_sync.addr0_state_bit_b; // see [RULE10] see [RULE16]
		bsr_capture[`JDR_CELL_A0A] = pin_sync.addr0_state_bit_a;
		bsr_capture[`JDR_CELL_A1B] = pin_sync.addr1_state_bit_b;
		bsr_capture[`JDR_CELL_A1A] = pin_sync.addr1_state_bit_a;
		bsr_capture[`JDR_CELL_SCL] = pin_sync.scl;
	end

	// ------------------------------------------------------------------------
	// Data register shift path
	// ------------------------------------------------------------------------

	// Shift one stage toward bit 0; TDI enters the top of the selected length.
	always_comb begin
		next_dr_shift = dr_shift >> 1;
		next_dr_shift[dr_len(instr) - 8'h01] = tdi_sync[1];
	end

	// Parallel load on the capture rise, shift on each shift rise.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dr_shift <= '0;
		end else if (tck_rise && tap == TAP_CAP_DR) begin
			dr_shift <= '0;
			if (instr == `JDR_OP_IDCODE) begin
				dr_shift[31:0] <= id_code;
			end else if (instr == `JDR_OP_USERCODE) begin
				dr_shift[31:0] <= user_code; // see [RULE3]
			end else if (is_bsr(instr)) begin
				dr_shift <= bsr_capture; // see [RULE12] see [RULE13]
			end else if (instr == `JDR_OP_LOAD_ADDR) begin
				dr_shift[7:0] <= mem_addr; // see [RULE4]
			end else if (instr == `JDR_OP_READ) begin
				dr_shift[7:0] <= mem_rdata; // see [RULE5] see [RULE20]
			end else if (instr == `JDR_OP_WRITE) begin
				dr_shift[7:0] <= mem_wdata; // see [RULE6]
			end
		end else if (tck_rise && tap == TAP_SHIFT_DR) begin
			dr_shift <= next_dr_shift; // see [RULE3]
		end
	end

	// ------------------------------------------------------------------------
	// Update-DR latches and memory port
	// ------------------------------------------------------------------------

	// Address, write data and boundary hold latch on the update falling TCK.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mem_addr <= 8'h00;
			mem_wdata <= 8'h00;
			bsr_hold <= '0;
		end else if (tck_fall && tap == TAP_UPD_DR) begin
			if (instr == `JDR_OP_LOAD_ADDR) begin
				mem_addr <= dr_shift[7:0]; // see [RULE4] see [RULE20]
			end else if (instr == `JDR_OP_WRITE) begin
				mem_wdata <= dr_shift[7:0]; // see [RULE6]
			end else if (is_bsr(instr)) begin
				bsr_hold <= dr_shift;
			end
		end
	end

	// Memory request; the write strobe lasts one core cycle.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mem_req <= '0;
		end else begin
			mem_req.addr <= mem_addr;
			mem_req.wdata <= (tck_fall && tap == TAP_UPD_DR) ? dr_shift[7:0] : mem_wdata;
			mem_req.write <= tck_fall && tap == TAP_UPD_DR && instr == `JDR_OP_WRITE;
		end
	end

	// ------------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------------

	assign extest_on = (instr == `JDR_OP_EXTEST);

	// Under extest each output follows its held cell, otherwise the core.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pin_out <= '0;
		end else if (extest_on) begin
			pin_out.gpio1 <= bsr_hold[`JDR_CELL_GPIO1_OUT]; // see [RULE13] see [RULE14]
			pin_out.gpio2 <= bsr_hold[`JDR_CELL_GPIO2_OUT];
			pin_out.sda <= bsr_hold[`JDR_CELL_SDA_OUT];
			pin_out.alert <= bsr_hold[`JDR_CELL_ALERT];
			pin_out.secondary_fault_b_out <= bsr_hold[`JDR_CELL_FAULT_B];
			pin_out.secondary_fault_a_out <= bsr_hold[`JDR_CELL_FAULT_A];
			pin_out.overtemperature_out <= bsr_hold[`JDR_CELL_OVERTEMP];
			pin_out.reset <= bsr_hold[`JDR_CELL_RESET];
			pin_out.overcurrent_out <= bsr_hold[`JDR_CELL_OVERCUR];
		end else begin
			pin_out <= func_out; // see [RULE12]
		end
	end

	// ------------------------------------------------------------------------
	// TDO
	// ------------------------------------------------------------------------

	// TDO changes on the falling TCK and is driven only while shifting.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			tdo_oe_n <= ~(tap == TAP_SHIFT_DR || tap == TAP_SHIFT_IR);
			tdo <= (tap == TAP_SHIFT_IR) ? ir_shift[0] : dr_shift[0];
		end
	end

	// ------------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------------

	// Zero wait states; unmapped addresses answer with an error.
	assign pready = 1'b1;
	assign pslverr = psel && penable &&
		(paddr != `JDR_OFS_CONFIG) && (paddr != `JDR_OFS_STATUS);

	// Configuration word feeds the user code.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfg <= `JDR_CFG_RESET;
		end else if (psel && penable && pwrite && paddr == `JDR_OFS_CONFIG) begin
			cfg <= {17'h0_0000, pwdata[14:0]};
		end
	end

	// Read data is registered in the setup cycle.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			if (paddr == `JDR_OFS_CONFIG) begin
				prdata <= cfg;
			end else if (paddr == `JDR_OFS_STATUS) begin
				prdata <= {mem_wdata, mem_addr, 4'h0, tap, 3'h0, instr};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

endmodule : jdr_top

// >>> common/jdr_consts.svh
`ifndef JDR_CONSTS_SVH
`define JDR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------------
`define JDR_IR_LEN 5
`define JDR_IR_CAPTURE 5'h01
`define JDR_OP_IDCODE 5'h00
`define JDR_OP_SAMPLE 5'h01
`define JDR_OP_EXTEST 5'h02
`define JDR_OP_USERCODE 5'h04
`define JDR_OP_LOAD_ADDR 5'h08
`define JDR_OP_READ 5'h09
`define JDR_OP_WRITE 5'h0A
`define JDR_OP_REBOOT 5'h0C
`define JDR_OP_SAVE 5'h0D
`define JDR_OP_BYPASS 5'h1F

// ----------------------------------------------------------------------------
// Data register lengths and field positions
// ----------------------------------------------------------------------------
`define JDR_BSR_LEN 198
`define JDR_ID_LEN 32
`define JDR_MEM_LEN 8
`define JDR_ID_VER_POS 28
`define JDR_ID_DEV_POS 12
`define JDR_ID_MFR_POS 1
`define JDR_UC_SLAVE_POS 8

// ----------------------------------------------------------------------------
// Boundary cell positions
// ----------------------------------------------------------------------------
`define JDR_CELL_GPIO1_OUT 148
`define JDR_CELL_GPIO2_OUT 149
`define JDR_CELL_SDA_OUT 150
`define JDR_CELL_ALERT 151
`define JDR_CELL_FAULT_B 152
`define JDR_CELL_FAULT_A 153
`define JDR_CELL_OVERTEMP 154
`define JDR_CELL_RESET 155
`define JDR_CELL_OVERCUR 156
`define JDR_CELL_GPIO2_IN 183
`define JDR_CELL_GPIO1_IN 184
`define JDR_CELL_SDA_IN 185
`define JDR_CELL_A0B 186
`define JDR_CELL_A0A 187
`define JDR_CELL_A1B 188
`define JDR_CELL_A1A 189
`define JDR_CELL_SCL 190

// ----------------------------------------------------------------------------
// APB register map and reset values
// ----------------------------------------------------------------------------
`define JDR_OFS_CONFIG 12'h000
`define JDR_OFS_STATUS 12'h004
`define JDR_CFG_FW_POS 0
`define JDR_CFG_SLAVE_POS 8
`define JDR_CFG_RESET 32'h0000_0000
`define JDR_STS_INSTR_POS 0
`define JDR_STS_TAP_POS 8
`define JDR_STS_ADDR_POS 16
`define JDR_STS_WDATA_POS 24

`endif

// >>> common/jdr_pkg.sv
package jdr_pkg;

	// TAP controller states.
	typedef enum logic [3:0] {
		TAP_RESET = 4'b0000,
		TAP_IDLE = 4'b0001,
		TAP_SEL_DR = 4'b0010,
		TAP_CAP_DR = 4'b0011,
		TAP_SHIFT_DR = 4'b0100,
		TAP_EXIT1_DR = 4'b0101,
		TAP_PAUSE_DR = 4'b0110,
		TAP_EXIT2_DR = 4'b0111,
		TAP_UPD_DR = 4'b1000,
		TAP_SEL_IR = 4'b1001,
		TAP_CAP_IR = 4'b1010,
		TAP_SHIFT_IR = 4'b1011,
		TAP_EXIT1_IR = 4'b1100,
		TAP_PAUSE_IR = 4'b1101,
		TAP_EXIT2_IR = 4'b1110,
		TAP_UPD_IR = 4'b1111
	} jdr_tap_t;

	// Digital outputs covered by the boundary register.
	typedef struct packed {
		logic gpio1;
		logic gpio2;
		logic sda;
		logic alert;
		logic secondary_fault_b_out;
		logic secondary_fault_a_out;
		logic overtemperature_out;
		logic reset;
		logic overcurrent_out;
	} jdr_pin_out_t;

	// Digital inputs covered by the boundary register.
	typedef struct packed {
		logic gpio2;
		logic gpio1;
		logic sda;
		logic addr0_state_bit_b;
		logic addr0_state_bit_a;
		logic addr1_state_bit_b;
		logic addr1_state_bit_a;
		logic scl;
	} jdr_pin_in_t;

	// Memory port toward the device's register space.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic write;
	} jdr_mem_req_t;

endpackage : jdr_pkg

// >>> testbench/jdr_top_props.sv
`timescale 1ns/1ps
// --------
// Port checker
// --------
module jdr_top_props
	import jdr_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	input wire jdr_mem_req_t mem_req,
	input wire logic reboot_pulse,
	input wire logic save_pulse,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	// Marks an access phase to an address outside the register map.
	logic unmapped;
	assign unmapped = psel && penable && paddr != 12'h000 && paddr != 12'h004;

	property p_reboot_once;
		reboot_pulse |=> !reboot_pulse [*8];
	endproperty
	a_reboot_once: assert property (p_reboot_once) else $error("reboot pulse repeats");
	property p_save_once;
		save_pulse |=> !save_pulse [*8];
	endproperty
	a_save_once: assert property (p_save_once) else $error("save pulse repeats");
	property p_opcodes_apart;
		(reboot_pulse || save_pulse) |-> tdo_oe_n && !mem_req.write;
	endproperty
	a_opcodes_apart: assert property (p_opcodes_apart) else $error("action pulse while shifting");
	property p_write_once;
		mem_req.write |=> !mem_req.write [*4];
	endproperty
	a_write_once: assert property (p_write_once) else $error("write pulse repeats");
	property p_addr_hold;
		mem_req.write |-> $stable(mem_req.addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved at write");
	property p_tdo_fall;
		$changed(tdo) |-> !tck;
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved with tck high");
	property p_oe_fall;
		$changed(tdo_oe_n) |-> !tck;
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("enable moved with tck high");
	property p_unmapped;
		unmapped |-> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mapped;
		psel && penable && !unmapped |-> !pslverr;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access refused");

	c_reboot: cover property (reboot_pulse);
	c_save: cover property (save_pulse);
	c_write: cover property (mem_req.write);
	c_refused: cover property (unmapped);
endmodule : jdr_top_props

bind jdr_top jdr_top_props u_props (.core_clk, .nrst, .tck, .tdo, .tdo_oe_n, .mem_req,
	.reboot_pulse, .save_pulse, .psel, .penable, .paddr, .prdata, .pslverr);

// >>> testbench/jdr_host.sv
`timescale 1ns/1ps
// --------
// Test controller model
// --------
module jdr_host (
	input wire logic core_clk,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	output logic tck,
	output logic tms,
	output logic tdi
);
	// The link clock rests low between frames; it starts with TMS high, holding the controller in test-logic-reset.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One 800 ns tck period; tdo is taken just before the rise.
	// A released tdo line reads inverted, so an undriven bit shows up as a mismatch.
	task automatic tclk(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge core_clk);
		q = tdo_oe_n ? ~tdo : tdo;
		tck <= 1'b1;
		repeat (4) @(posedge core_clk);
		tck <= 1'b0;
	endtask : tclk

	// Instruction scan from idle, least significant bit first, back to idle.
	task automatic ir(input logic [4:0] op, output logic [4:0] cap);
		logic q;
		tclk(1'b1, 1'b0, q);
		tclk(1'b1, 1'b0, q);
		tclk(1'b0, 1'b0, q);
		tclk(1'b0, 1'b0, q);
		for (int i = 0; i < 5; i++) begin
			tclk(i == 4, op[i], q);
			cap[i] = q;
		end
		tclk(1'b1, 1'b0, q);
		tclk(1'b0, 1'b0, q);
	endtask : ir

	// Data scan of n bits from idle, back to idle.
	task automatic dr(input int n, input logic [199:0] din, output logic [199:0] dout);
		logic q;
		dout = '0;
		tclk(1'b1, 1'b0, q);
		tclk(1'b0, 1'b0, q);
		tclk(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			tclk(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tclk(1'b1, 1'b0, q);
		tclk(1'b0, 1'b0, q);
	endtask : dr
endmodule : jdr_host

// >>> testbench/jtag_data_registers_ext_tb_top.sv
`timescale 1ns/1ps
`include "jdr_consts.svh"
// --------
// Bench top
// --------
module jtag_data_registers_ext_tb_top
	import jdr_pkg::*;
;
	typedef struct {
		logic [4:0] op;
		int n;
		logic [31:0] din;
		logic [31:0] exp;
		logic [31:0] mask;
		logic [7:0] addr;
		logic [7:0] wdata;
	} jdr_row_t;

	// Identity fields are arbitrary values of our own.
	localparam logic [31:0] ID_WORD = {4'h3, 16'h5a3c, 11'h2e1, 1'b1};

	logic core_clk, nrst, tck, tms, tdi, tdo, tdo_oe_n, reboot_pulse, save_pulse;
	logic psel, penable, pwrite, pready, pslverr, er, q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] mem_rdata;
	logic [4:0] cap;
	logic [199:0] dout;
	jdr_pin_out_t func_out, pin_out;
	jdr_pin_in_t pin_in;
	jdr_mem_req_t mem_req;
	int err_total, n_tests, cyc, rb_cnt, sv_cnt, wr_cnt;

	jdr_row_t rows[6] = '{
		'{`JDR_OP_IDCODE, 32, 32'h0, ID_WORD, 32'hffff_ffff, 8'h00, 8'h00},
		'{`JDR_OP_USERCODE, 32, 32'h0, 32'h0000_2b5c, 32'hffff_ffff, 8'h00, 8'h00},
		'{`JDR_OP_BYPASS, 2, 32'h1, 32'h2, 32'h3, 8'h00, 8'h00},
		'{`JDR_OP_LOAD_ADDR, 8, 32'ha5, 32'h0, 32'hff, 8'ha5, 8'h00},
		'{`JDR_OP_WRITE, 8, 32'h5a, 32'h0, 32'hff, 8'ha5, 8'h5a},
		'{`JDR_OP_READ, 8, 32'h0, 32'h99, 32'hff, 8'ha5, 8'h5a}
	};

	jdr_top #(.ID_VERSION(4'h3), .ID_DEVICE(16'h5a3c), .ID_MAKER(11'h2e1)) dut (.core_clk,
		.nrst, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .func_out, .pin_out, .pin_in, .mem_req,
		.mem_rdata, .reboot_pulse, .save_pulse, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);
	jdr_host host (.core_clk, .tdo, .tdo_oe_n, .tck, .tms, .tdi);

	// Clock of 100 ns period.
	always #50 core_clk = ~core_clk;

	// Memory answers with a byte derived from the address; pulses are counted.
	always @(posedge core_clk) begin
		mem_rdata <= mem_req.addr ^ 8'h3c;
		rb_cnt <= rb_cnt + int'(reboot_pulse);
		sv_cnt <= sv_cnt + int'(save_pulse);
		wr_cnt <= wr_cnt + int'(mem_req.write);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end

	// Compares one value and reports a mismatch.
	task automatic chk(input string name, input logic [199:0] seen, input logic [199:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", name, exp, seen);
		end
	endtask : chk

	// One APB transfer; waits for pready and takes the answer at that edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	// Expected boundary capture from output and input pin values.
	function automatic logic [199:0] bsr(input jdr_pin_out_t o, input jdr_pin_in_t p);
		logic [199:0] v;
		v = '0;
		for (int i = 0; i < 9; i++)
			v[148 + i] = o[8 - i];
		for (int i = 0; i < 8; i++)
			v[183 + i] = p[7 - i];
		return v;
	endfunction : bsr

	// Prints the verdict and ends the run.
	task automatic finish_test;
		if (err_total == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	// --------
	// Main sequence
	// --------
	initial begin
		{core_clk, nrst, psel, penable, pwrite} = '0;
		{paddr, pwdata, err_total, n_tests, cyc, rb_cnt, sv_cnt, wr_cnt} = '0;
		func_out = 9'h0a5;
		pin_in = 8'hac;
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		host.tclk(1'b0, 1'b0, q);
		apb(1'b1, 12'h000, 32'hffff_ab5c);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk("config", rd, 32'h0000_2b5c);
		apb(1'b1, 12'h008, 32'hffff_ffff);
		chk("unmapped err", er, 1'b1);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk("unmapped data", rd, 32'h0000_0000);
		// Address is loaded before the write and the read.
		for (int r = 0; r < 6; r++) begin
			host.ir(rows[r].op, cap);
			chk("ir capture", cap, 5'h01);
			host.dr(rows[r].n, rows[r].din, dout);
			chk("dr out", dout[31:0] & rows[r].mask, rows[r].exp);
			chk("mem addr", mem_req.addr, rows[r].addr);
			chk("mem wdata", mem_req.wdata, rows[r].wdata);
		end
		chk("write pulses", wr_cnt, 1);
		chk("tdo released", tdo_oe_n, 1'b1);
		// Status shows write byte, address, idle state and the read instruction.
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("status", rd, 32'h5aa5_0109);
		host.ir(`JDR_OP_REBOOT, cap);
		chk("reboot", {rb_cnt, sv_cnt}, {32'd1, 32'd0});
		host.ir(`JDR_OP_SAVE, cap);
		chk("save", {rb_cnt, sv_cnt}, {32'd1, 32'd1});
		// Boundary scan: sample with preload, then external test.
		host.ir(`JDR_OP_SAMPLE, cap);
		host.dr(198, bsr(9'h0c3, 8'h00), dout);
		chk("sample cap", dout, bsr(9'h0a5, 8'hac));
		chk("sample pins", pin_out, func_out);
		host.ir(`JDR_OP_EXTEST, cap);
		chk("extest drive", pin_out, 9'h0c3);
		func_out <= 9'h15a;
		pin_in <= 8'h53;
		host.dr(199, 200'h1, dout);
		chk("extest cap", dout[197:0], bsr(9'h15a, 8'h53));
		chk("chain length", dout[198], 1'b1);
		chk("extest zero", pin_out, 9'h000);
		host.ir(`JDR_OP_BYPASS, cap);
		chk("pins back", pin_out, 9'h15a);
		// Instruction returns to identification after either kind of reset.
		for (int k = 0; k < 2; k++) begin
			host.ir(`JDR_OP_BYPASS, cap);
			if (k == 0) begin
				repeat (5) host.tclk(1'b1, 1'b0, q);
			end else begin
				nrst <= 1'b0;
				@(posedge core_clk);
				nrst <= 1'b1;
				repeat (3) @(posedge core_clk);
			end
			host.tclk(1'b0, 1'b0, q);
			host.dr(32, 200'h0, dout);
			chk("id after reset", dout, ID_WORD);
		end
		finish_test();
	end
endmodule : jtag_data_registers_ext_tb_top
